// [sim/testbench.sv]
// testbench: register and serial scenarios for the uart slice
// assumes ups_uart as the block and ups_remote on its pins
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ups_pkg::*;
  logic        clk_i, rst_n, cyc, stb, we, busy_opt;
  logic [15:0] adr;
  logic [31:0] dat_w, dat_r;
  logic        ack, tx_a, oe_a, tx_b, oe_b, free_o, eclk_free;
  logic        rx_a, rx_b, ext_clk;
  int          err_count, total_checks;
  // released tx pins float high through the board pull-ups
  wire logic   line_a = oe_a ? tx_a : 1'b1;
  wire logic   line_b = oe_b ? tx_b : 1'b1;

  ups_uart ups_uart_inst (
    .CLK_I(clk_i), .RESET_N_I(rst_n), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(4'h1), .DAT_I(dat_w), .DAT_O(dat_r),
    .ACK_O(ack), .RX_PIN_A_I(rx_a), .RX_PIN_B_I(rx_b),
    .EXT_BAUD_CLOCK_PIN_I(ext_clk), .TX_PIN_A_O(tx_a),
    .TX_PIN_A_OE_O(oe_a), .TX_PIN_B_O(tx_b), .TX_PIN_B_OE_O(oe_b),
    .CH1_BUSY_OPT_I(busy_opt), .DATA_PINS_FREE_O(free_o),
    .EXT_CLK_PORT_FREE_O(eclk_free));

  ups_remote ups_remote_inst (
    .ext_clk_o(ext_clk), .rx_a_o(rx_a), .rx_b_o(rx_b),
    .tx_a_i(line_a), .tx_b_i(line_b));

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [15:0] a,
                    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_r[7:0];
    if (n >= 20) chk("ack", 8'h01, 8'h00);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] v;
    wb(1'b1, a, d, v);
  endtask : wr

  task automatic rdc(input string n, input logic [15:0] a,
                     input logic [7:0] e);
    logic [7:0] v;
    wb(1'b0, a, 8'h00, v);
    chk(n, e, v);
  endtask : rdc

  // order: pins free, ext clock free, oe a, oe b
  task automatic pins(input logic [3:0] e);
    repeat (4) @(posedge clk_i);
    chk("pins", {4'h0, e}, {4'h0, free_o, eclk_free, oe_a, oe_b});
  endtask : pins

  // both directions at once; k = 3 gives 1140 ns per bit
  task automatic duplex(input logic b, input logic [7:0] rx,
                        input logic [7:0] tx);
    logic [7:0] got;
    int         wid;
    logic       ok;
    fork
      ups_remote_inst.send(b, rx);
      wr(IDX_DATA, tx);
      ups_remote_inst.catch(b, got, wid, ok);
    join
    chk("tx_byte", tx, got);
    chk("tx_stop", 8'h01, {7'h00, ok});
    chk("bit_time", 8'h01, {7'h00, wid > 1130 && wid < 1150});
    rdc("rx_byte", IDX_DATA, rx);
    rdc("tx_busy", IDX_ASYNC_STATUS, 8'h01 << STAT_TXBUSY);
    // stop bits may still be on the line; let them pass
    #(2 * ups_remote_inst.bit_ns);
    rdc("status", IDX_ASYNC_STATUS, 8'h00);
  endtask : duplex

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // a hang ends the run the same way the tests do
  initial begin
    #300000;
    err_count++;
    give_verdict();
  end

  initial begin
    {rst_n, cyc, stb, we, busy_opt} = 5'h00;
    adr = 16'h0000;
    dat_w = 32'h00000000;
    err_count = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_n <= 1'b1;
    rdc("mode_rst", IDX_ASYNC_MODE, 8'h00);
    rdc("stat_rst", IDX_ASYNC_STATUS, 8'h00);
    rdc("route_rst", IDX_PIN_ROUTE, 8'h00);
    rdc("unmapped", 16'hFF00, 8'h00);
    pins(4'hC);
    wr(IDX_PIN_ROUTE, 8'hFF);
    rdc("route_bits", IDX_PIN_ROUTE, 8'h30);
    // software stops the channel before every route or clocked serial mode change
    wr(IDX_PIN_ROUTE, 8'h00);
    wr(IDX_CLK_SER_MODE, 8'h00);
    wr(IDX_BAUD_GEN, 8'h03);
    ups_remote_inst.set_k(4'h3);
    wr(IDX_ASYNC_MODE, 8'hC0);
    pins(4'h2);
    duplex(1'b0, 8'h3C, 8'hA5);
    wr(IDX_ASYNC_MODE, 8'h00);
    wr(IDX_PIN_ROUTE, 8'h30);
    wr(IDX_ASYNC_MODE, 8'hC4);
    pins(4'h1);
    duplex(1'b1, 8'h3B, 8'h5B);
    // overrun keeps flagging until the buffer is read
    ups_remote_inst.send(1'b1, 8'h11);
    ups_remote_inst.send(1'b1, 8'h22);
    rdc("ovr_first", IDX_ASYNC_STATUS, 8'h01);
    ups_remote_inst.send(1'b1, 8'h33);
    rdc("ovr_again", IDX_ASYNC_STATUS, 8'h01);
    rdc("ovr_kept", IDX_DATA, 8'h11);
    ups_remote_inst.send(1'b1, 8'h44);
    rdc("ovr_gone", IDX_ASYNC_STATUS, 8'h00);
    rdc("ovr_data", IDX_DATA, 8'h44);
    busy_opt <= 1'b1;
    pins(4'h0);
    busy_opt <= 1'b0;
    wr(IDX_ASYNC_MODE, 8'h40);
    pins(4'h0);
    wr(IDX_ASYNC_MODE, 8'h41);
    pins(4'h4);
    // three-wire mode: neither stop nor uart, nothing freed or driven
    wr(IDX_ASYNC_MODE, 8'h00);
    wr(IDX_CLK_SER_MODE, 8'h80);
    pins(4'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// [sim/ups_remote.sv]
// ups_remote: behavioural remote uart facing the serial pins
// assumes resolved idle-high tx lines and a free-running baud oscillator
`timescale 1ns/1ns
`default_nettype none
module ups_remote #(
  parameter int unsigned HALF_NS = 15
) (
  // oscillator and lines toward the block
  output var logic ext_clk_o,
  output var logic rx_a_o,
  output var logic rx_b_o,
  // resolved transmit lines from the block
  input  wire logic tx_a_i,
  input  wire logic tx_b_i
);
  int unsigned bit_ns;

  // lines idle high; oscillator runs free like a crystal on the pin
  initial begin
    ext_clk_o = 1'b0;
    rx_a_o    = 1'b1;
    rx_b_o    = 1'b1;
    bit_ns    = 64 * HALF_NS;
  end
  // non-blocking, since some toggles land on a system clock edge
  always #(HALF_NS) ext_clk_o <= ~ext_clk_o;

  // bit time is 2(k+16) oscillator periods
  task automatic set_k(input logic [3:0] k);
    bit_ns = 4 * (int'(k) + 16) * HALF_NS;
  endtask : set_k

  function automatic logic line(input logic b);
    return b ? tx_b_i : tx_a_i;
  endfunction : line

  // one frame, lsb first, always a single stop bit
  task automatic send(input logic b, input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      if (b) begin
        rx_b_o <= f[i];
      end else begin
        rx_a_o <= f[i];
      end
      #(bit_ns);
    end
  endtask : send

  // limitation: needs an odd byte so the start bit ends on a rise
  task automatic catch(input logic b, output logic [7:0] d,
                       output int w, output logic ok);
    int n;
    n = 0;
    w = 0;
    d = 8'h00;
    while (line(b) !== 1'b0 && n < 40000) begin
      #4;
      n++;
    end
    while (line(b) === 1'b0 && w < 4000) begin
      #1;
      w++;
    end
    #(bit_ns / 2);
    d[0] = line(b);
    for (int i = 1; i < 8; i++) begin
      #(bit_ns);
      d[i] = line(b);
    end
    #(bit_ns);
    ok = (n < 40000) && (line(b) === 1'b1);
  endtask : catch
endmodule : ups_remote
`default_nettype wire

// [src/ups_baud.sv]
// ups_baud: divides source ticks by k + 16 per half bit
// assumes src_tick_i is a one-cycle pulse on the same clock
`timescale 1ns/1ns
`default_nettype none
module ups_baud
  import ups_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // control
  input  wire logic       src_tick_i,
  input  wire logic       clear_i,
  input  wire logic [3:0] k_i,
  // half-bit and full-bit pulses
  output logic            half_o,
  output logic            rise_o
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       bclk;
    logic       half;
    logic       rise;
  } ups_baud_s;
  ups_baud_s  q;
  ups_baud_s  n;
  logic [4:0] term;

  // last count of a half period
  assign term = 5'(BG_BASE + {1'b0, k_i}) - 5'h01;

  // reload at k + 16 and toggle, giving even duty
  always_comb begin
    n      = q;
    n.half = 1'b0;
    n.rise = 1'b0;
    if (clear_i) begin
      n.cnt  = '0;
      n.bclk = 1'b0;
    end else if (src_tick_i) begin
      if (q.cnt == term) begin
        n.cnt  = '0;
        n.bclk = ~q.bclk;
        n.half = 1'b1;
        n.rise = ~q.bclk;
      end else begin
        n.cnt = q.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign half_o = q.half;
  assign rise_o = q.rise;

  half_toggle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    src_tick_i && !clear_i && q.cnt == term |=> half_o && q.bclk != $past(q.bclk))
    else $error("half period did not end at k plus 16");
endmodule : ups_baud
`default_nettype wire

// [src/ups_pkg.sv]
// ups_pkg: constants and types for the uart pin-select block
// assumes a 250 MHz system clock and a wishbone register port
`default_nettype none
package ups_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ      = 250_000_000;
  // internal baud source: 1000 kHz, so k = 0 gives 31.25 kbps
  localparam int unsigned INT_SRC_KHZ = 1000;
  localparam int unsigned INT_SRC_DIV = CLK_HZ / (INT_SRC_KHZ * 1000);
  localparam logic [7:0]  INT_DIV_LAST = 8'(INT_SRC_DIV - 1);
  // divider base: each half bit lasts k + 16 source ticks
  localparam logic [4:0]  BG_BASE     = 5'h10;

  // register indexes; byte address is four times the index
  localparam logic [15:0] IDX_ASYNC_MODE   = 16'hFF70;
  localparam logic [15:0] IDX_ASYNC_STATUS = 16'hFF71;
  localparam logic [15:0] IDX_CLK_SER_MODE = 16'hFF72;
  localparam logic [15:0] IDX_BAUD_GEN     = 16'hFF73;
  localparam logic [15:0] IDX_DATA         = 16'hFF74;
  localparam logic [15:0] IDX_PIN_ROUTE    = 16'hFF75;
  localparam logic [7:0]  REG_RESET        = 8'h00;

  // async mode fields
  localparam int unsigned MODE_TXE     = 7;
  localparam int unsigned MODE_RXE     = 6;
  localparam int unsigned MODE_SL      = 2;
  localparam int unsigned MODE_SRC_INT = 0;
  // async status fields
  localparam int unsigned STAT_OVR     = 0;
  localparam int unsigned STAT_FE      = 1;
  localparam int unsigned STAT_TXBUSY  = 2;
  // clocked serial mode: three-wire enable
  localparam int unsigned CSM_THREE    = 7;
  // pin route fields; other bits read zero
  localparam int unsigned ROUTE_TX     = 5;
  localparam int unsigned ROUTE_RX     = 4;
  localparam logic [7:0]  ROUTE_MASK   = 8'h30;

  // frame lengths in bit ticks, plus one lead tick
  localparam logic [3:0]  TX_LOAD_1    = 4'hB;
  localparam logic [3:0]  TX_LOAD_2    = 4'hC;
  localparam logic [3:0]  DATA_BITS    = 4'h8;

  // operating modes, exactly three
  typedef enum logic [2:0] {
    MODE_STOP  = 3'h1,
    MODE_UART  = 3'h2,
    MODE_3WIRE = 3'h4
  } ups_mode_e;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_SHIFT = 2'h2
  } ups_tx_e;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h1,
    RX_START = 3'h2,
    RX_DATA  = 3'h4
  } ups_rx_e;
endpackage : ups_pkg
`default_nettype wire

// [src/ups_sync.sv]
// ups_sync: two flip-flop synchroniser for pin inputs
// assumes inputs asynchronous to clk_i; idle level given by INIT
`timescale 1ns/1ns
`default_nettype none
module ups_sync #(
  parameter int unsigned     W    = 1,
  parameter logic [W-1:0]    INIT = '1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  // pins in, synchronised out
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ups_sync_s;
  ups_sync_s q;
  ups_sync_s n;

  // first stage feeds only the second
  always_comb begin
    n    = q;
    n.s1 = pin_i;
    n.s2 = q.s1;
  end

  // register with idle level at reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= {INIT, INIT};
    end else begin
      q <= n;
    end
  end

  assign sync_o = q.s2;
endmodule : ups_sync
`default_nettype wire

// [src/ups_uart.sv]
// ups_uart: uart slice with pin routing and external baud source
// assumes a classic wishbone master and a remote uart on the pins
//
// How it works
// - external rate is pin clock over 2(k+16)
// - route bits pick first or second pin
// - route bits act only while enables set
// - exactly three modes: stop, uart, three-wire
// - stop mode: no transfer, pins released
// - byte after start bit, full duplex
// - only one tx pin and one rx pin used at once
// - internal source frees external clock pin
// - overrun repeats until receive buffer read
// - receiver checks only one stop bit
// - reset clears mode, status, route registers
// - baud generator can produce 31.25 kbps
// - busy option on channel 1 blocks pair b
// - route register byte writable, unused bits zero
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ups_uart
  import ups_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [17:2] ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  // serial pins
  input  wire logic        RX_PIN_A_I,
  input  wire logic        RX_PIN_B_I,
  input  wire logic        EXT_BAUD_CLOCK_PIN_I,
  output logic             TX_PIN_A_O,
  output logic             TX_PIN_A_OE_O,
  output logic             TX_PIN_B_O,
  output logic             TX_PIN_B_OE_O,
  // port sharing
  input  wire logic        CH1_BUSY_OPT_I,
  output logic             DATA_PINS_FREE_O,
  output logic             EXT_CLK_PORT_FREE_O
);
  // whole block state
  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  amode;
    logic [7:0]  astat;
    logic [7:0]  csm;
    logic [7:0]  brg;
    logic [7:0]  route;
    logic [7:0]  receive_buffer;
    logic        rx_full;
    ups_mode_e   mode;
    ups_tx_e     tx_st;
    logic [11:0] tx_sr;
    logic [3:0]  tx_cnt;
    ups_rx_e     rx_st;
    logic [7:0]  rx_sr;
    logic [3:0]  rx_cnt;
    logic        rx_ph;
    logic        rx_prev;
    logic [7:0]  div;
    logic        src_tick;
    logic        ext_prev;
    logic        tx_line;
    logic        tx_a_oe;
    logic        tx_b_oe;
    logic        pins_free;
    logic        clk_free;
  } ups_top_s;
  ups_top_s    q;
  ups_top_s    n;

  logic [2:0]  sync_q;
  logic        ext_s;
  logic        req;
  logic        wr;
  logic        data_wr;
  logic        data_rd;
  logic        stat_rd;
  logic        transmit_enable_flag;
  logic        receive_enable_flag;
  logic        tx_pick;
  logic        rx_pick;
  logic        src_int;
  logic        tx_on;
  logic        rx_on;
  logic        rx_line;
  logic        tx_go;
  logic        rx_end;
  logic        tx_bit;
  logic        rx_half;

  // all pins pass two flops before use
  ups_sync #(
    .W    (3),
    .INIT (3'h7)
  ) u_sync (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .pin_i     ({EXT_BAUD_CLOCK_PIN_I, RX_PIN_B_I, RX_PIN_A_I}),
    .sync_o    (sync_q)
  );
  assign ext_s = sync_q[2];

  // transmit divider runs only while transmit is enabled
  ups_baud u_tx_baud (
    .clk_i      (CLK_I),
    .reset_n_i  (RESET_N_I),
    .src_tick_i (q.src_tick),
    .clear_i    (!tx_on),
    .k_i        (q.brg[3:0]),
    .half_o     (),
    .rise_o     (tx_bit)
  );

  // receive divider held clear while idle, so the first
  // half pulse lands in the middle of the start bit
  ups_baud u_rx_baud (
    .clk_i      (CLK_I),
    .reset_n_i  (RESET_N_I),
    .src_tick_i (q.src_tick),
    .clear_i    (q.rx_st == RX_IDLE),
    .k_i        (q.brg[3:0]),
    .half_o     (rx_half),
    .rise_o     ()
  );

  // bus decode; one wait state, side effects at the taking edge
  assign req     = CYC_I && STB_I && !q.ack;
  assign wr      = req && WE_I && SEL_I[0];
  assign data_wr = wr && ADR_I == IDX_DATA;
  assign data_rd = req && !WE_I && ADR_I == IDX_DATA;
  assign stat_rd = req && !WE_I && ADR_I == IDX_ASYNC_STATUS;

  // control fields
  assign transmit_enable_flag     = q.amode[MODE_TXE];
  assign receive_enable_flag     = q.amode[MODE_RXE];
  assign src_int = q.amode[MODE_SRC_INT];
  assign tx_pick = q.route[ROUTE_TX];
  assign rx_pick = q.route[ROUTE_RX];
  assign tx_on   = q.mode == MODE_UART && transmit_enable_flag;
  assign rx_on   = q.mode == MODE_UART && receive_enable_flag;

  // one receive pin at a time; pair b unusable under busy option
  assign rx_line = !rx_on
                 | (rx_pick ? (CH1_BUSY_OPT_I | sync_q[1])
                            : sync_q[0]);

  assign tx_go  = data_wr && tx_on && q.tx_st == TX_IDLE;
  assign rx_end = q.rx_st == RX_DATA && rx_half && q.rx_ph
               && q.rx_cnt == DATA_BITS;

  // next state
  always_comb begin
    n          = q;
    n.ack      = req;
    n.src_tick = 1'b0;
    n.ext_prev = ext_s;

    // baud source: internal divider or external pin edges
    if (src_int) begin
      if (q.div == INT_DIV_LAST) begin
        n.div      = '0;
        n.src_tick = 1'b1;
      end else begin
        n.div = q.div + 8'h01;
      end
    end else begin
      n.div      = '0;
      n.src_tick = ext_s & ~q.ext_prev;
    end

    // register reads; unmapped reads give zero
    if (req && !WE_I) begin
      case (ADR_I)
        IDX_ASYNC_MODE:   n.rdata = q.amode;
        IDX_ASYNC_STATUS: begin
          n.rdata = q.astat;
          n.rdata[STAT_TXBUSY] = q.tx_st == TX_SHIFT;
        end
        IDX_CLK_SER_MODE: n.rdata = q.csm;
        IDX_BAUD_GEN:     n.rdata = q.brg;
        IDX_DATA:         n.rdata = q.receive_buffer;
        IDX_PIN_ROUTE:    n.rdata = q.route & ROUTE_MASK;
        default:          n.rdata = REG_RESET;
      endcase
    end

    // register writes; unmapped writes are dropped
    if (wr) begin
      case (ADR_I)
        IDX_ASYNC_MODE:   n.amode = DAT_I[7:0];
        IDX_CLK_SER_MODE: n.csm   = DAT_I[7:0];
        IDX_BAUD_GEN:     n.brg   = DAT_I[7:0];
        IDX_PIN_ROUTE:    n.route = DAT_I[7:0] & ROUTE_MASK;
        default:          n.rdata = n.rdata;
      endcase
    end

    // read clears come first so a same-cycle event wins
    if (stat_rd) begin
      n.astat = REG_RESET;
    end
    if (data_rd) begin
      n.rx_full = 1'b0;
    end

    // mode from the mode registers
    if (q.csm[CSM_THREE]) begin
      n.mode = MODE_3WIRE;
    end else if (transmit_enable_flag || receive_enable_flag) begin
      n.mode = MODE_UART;
    end else begin
      n.mode = MODE_STOP;
    end

    // transmitter: a lead tick aligns the start bit to the divider
    if (!tx_on) begin
      n.tx_st = TX_IDLE;
      n.tx_sr = '1;
    end else if (tx_go) begin
      n.tx_st  = TX_SHIFT;
      n.tx_sr  = {2'h3, DAT_I[7:0], 2'h1};
      n.tx_cnt = q.amode[MODE_SL] ? TX_LOAD_2 : TX_LOAD_1;
    end else if (q.tx_st == TX_SHIFT && tx_bit) begin
      n.tx_sr  = {1'b1, q.tx_sr[11:1]};
      n.tx_cnt = q.tx_cnt - 4'h1;
      if (q.tx_cnt == 4'h1) begin
        n.tx_st = TX_IDLE;
      end
    end
    n.tx_line = n.tx_st == TX_SHIFT ? n.tx_sr[0] : 1'b1;

    // drivers follow route only while transmit is enabled
    n.tx_a_oe   = tx_on && !tx_pick;
    n.tx_b_oe   = tx_on && tx_pick && !CH1_BUSY_OPT_I;
    n.pins_free = n.mode == MODE_STOP;
    n.clk_free  = src_int || n.mode == MODE_STOP;

    // receiver: runs alongside the transmitter
    n.rx_prev = rx_line;
    if (!rx_on) begin
      n.rx_st = RX_IDLE;
    end else begin
      unique case (q.rx_st)
        RX_IDLE: begin
          if (q.rx_prev && !rx_line) begin
            n.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (rx_half) begin
            n.rx_st  = rx_line ? RX_IDLE : RX_DATA;
            n.rx_cnt = '0;
            n.rx_ph  = 1'b0;
          end
        end
        RX_DATA: begin
          if (rx_half) begin
            n.rx_ph = ~q.rx_ph;
            if (q.rx_ph && q.rx_cnt != DATA_BITS) begin
              n.rx_sr  = {rx_line, q.rx_sr[7:1]};
              n.rx_cnt = q.rx_cnt + 4'h1;
            end else if (rx_end) begin
              // only the first stop bit is looked at
              n.rx_st = RX_IDLE;
              if (!rx_line) begin
                n.astat[STAT_FE] = 1'b1;
              end
              if (n.rx_full) begin
                n.astat[STAT_OVR] = 1'b1;
              end else begin
                n.receive_buffer     = q.rx_sr;
                n.rx_full = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  // state register; all but the state and idle-high line flops clear to zero at reset
  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      q         <= '0;
      q.mode    <= MODE_STOP;
      q.tx_st   <= TX_IDLE;
      q.rx_st   <= RX_IDLE;
      q.tx_sr   <= '1;
      q.tx_line <= 1'b1;
      q.rx_prev <= 1'b1;
      q.ext_prev <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // outputs straight from flops
  assign DAT_O               = {24'h000000, q.rdata};
  assign ACK_O               = q.ack;
  assign TX_PIN_A_O          = q.tx_line;
  assign TX_PIN_B_O          = q.tx_line;
  assign TX_PIN_A_OE_O       = q.tx_a_oe;
  assign TX_PIN_B_OE_O       = q.tx_b_oe;
  assign DATA_PINS_FREE_O    = q.pins_free;
  assign EXT_CLK_PORT_FREE_O = q.clk_free;

  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RESET_N_I);

  sequence s_tx_load;
    tx_go;
  endsequence
  sequence s_tx_framed;
    q.tx_st == TX_SHIFT && q.tx_sr[1:0] == 2'h1;
  endsequence

  tx_frame_a: assert property (s_tx_load |=> s_tx_framed)
    else $error("transmit frame not loaded");
  route_tx_a: assert property (
    TX_PIN_A_OE_O |-> $past(transmit_enable_flag) && !$past(tx_pick))
    else $error("pin a driven without enable or route");
  one_set_a: assert property (!(TX_PIN_A_OE_O && TX_PIN_B_OE_O))
    else $error("both transmit pins driven");
  stop_free_a: assert property (q.mode == MODE_STOP && n.mode == MODE_STOP
    |=> !TX_PIN_A_OE_O && !TX_PIN_B_OE_O && DATA_PINS_FREE_O)
    else $error("pins held in stop mode");
  ext_free_a: assert property (src_int |=> EXT_CLK_PORT_FREE_O)
    else $error("clock pin not freed on internal source");
  busy_pair_a: assert property (CH1_BUSY_OPT_I |=> !TX_PIN_B_OE_O)
    else $error("pair b used under busy option");
  route_rx_a: assert property (rx_on && rx_pick && !CH1_BUSY_OPT_I
    && q.rx_st == RX_IDLE && q.rx_prev && !sync_q[1]
    |=> q.rx_st == RX_START)
    else $error("receive not taken from pin b");
  ovr_repeat_a: assert property (rx_on && rx_end && q.rx_full && !data_rd
    |=> q.astat[STAT_OVR])
    else $error("overrun not flagged");
  one_stop_a: assert property (rx_on && rx_end && rx_line && !q.rx_full
    |=> q.rx_full && q.rx_st == RX_IDLE ##1 q.rx_st != RX_START)
    else $error("byte not taken after one stop bit");
  ext_tick_a: assert property (!src_int && ext_s && !q.ext_prev
    |=> q.src_tick)
    else $error("external edge gave no source tick");
  reset_zero_a: assert property (@(posedge CLK_I) disable iff (1'b0)
    !RESET_N_I |=> q.amode == REG_RESET && q.astat == REG_RESET
    && q.route == REG_RESET)
    else $error("registers not cleared by reset");
endmodule : ups_uart
`default_nettype wire
